// File: rtl/asp_top.sv
// asynchronous serial port with reload-timer bit rate generator
//
// Contract
// - full-duplex port with 8-bit and 9-bit variable-rate frame modes
// - data writes load transmit register; transmit register never readable
// - data reads return the buffered receive register
// - received byte is buffered so next reception may start
// - enabled interrupt raised when transmit or receive done flag sets
// - done flags stay set until software clears them
// - transmit bit timing from count byte overflows in auto-reload mode
// - hidden receive counter runs with timer, reloads from same value
// - both counter overflow streams are halved to give bit rates
// - start edge on receive pin forces receive counter reload
// - timer clock from six selectable sources
// - overflow rate is timer clock over 256 minus reload
// - 8-bit frame: start, eight data bits lsb first, stop
// - 9-bit frame adds ninth bit from control bit TB8 before stop
// - transmit done flag sets at start of stop bit
// - receive loads only if flag clear and filter passes
`timescale 1ns/1ns
`include "asp_map.svh"
module asp_top import asp_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic ext_osc_tick,
  input wire logic reload_timer_ext_input,
  output logic irq
);
  // ==========================================
  // register state
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] reload_ff;
  logic [7:0] nxt_reload;
  logic [7:0] tcfg_ff;
  logic [7:0] nxt_tcfg;
  logic [1:0] int_stat_ff;
  logic [1:0] nxt_int_stat;
  logic [1:0] int_en_ff;
  logic [1:0] nxt_int_en;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] rx_buf_ff;
  logic [7:0] nxt_rx_buf;
  // ==========================================
  // transmit state
  logic [9:0] tx_sh_ff;
  logic [9:0] nxt_tx_sh;
  logic [3:0] tx_cnt_ff;
  logic [3:0] nxt_tx_cnt;
  logic tx_pend_ff;
  logic nxt_tx_pend;
  logic tx_busy_ff;
  logic nxt_tx_busy;
  logic tx_pin_ff;
  logic nxt_tx_pin;
  // ==========================================
  // receive state
  asp_rx_state_t rx_st_ff;
  asp_rx_state_t nxt_rx_st;
  logic [8:0] rx_sh_ff;
  logic [8:0] nxt_rx_sh;
  logic [3:0] rx_cnt_ff;
  logic [3:0] nxt_rx_cnt;
  logic rx_prev_ff;
  logic nxt_rx_prev;
  // ==========================================
  // wires
  logic t_tick;
  logic tx_bit;
  logic rx_bit;
  logic [7:0] tx_count;
  logic run;
  logic mode9;
  logic rx_start;
  logic tx_done_set;
  logic rx_done_set;
  logic wr_ctrl;
  logic wr_data;
  logic wr_count;
  logic [3:0] rx_last;
  logic rx_ok;
  logic [1:0] ev;
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
    hit = s && (a == off);
  endfunction
  always_comb begin
    run = tcfg_ff[`ASP_TCFG_RUN];
    mode9 = ctrl_ff[`ASP_CTL_MODE];
    wr_ctrl = hit(addr, `ASP_OFF_CTRL, wr_en);
    wr_data = hit(addr, `ASP_OFF_DATA, wr_en);
    wr_count = hit(addr, `ASP_OFF_COUNT, wr_en);
    rx_start = run && ctrl_ff[`ASP_CTL_REN] && (rx_st_ff == ASP_RX_IDLE)
               && rx_prev_ff && !rx_pin;
  end
  // ==========================================
  // bit rate generation
  asp_tick_gen u_tick (
    .clock(clock),
    .reset(reset),
    .src_sel(tcfg_ff[`ASP_TCFG_SRC_HI:`ASP_TCFG_SRC_LO]),
    .ext_osc_tick(ext_osc_tick),
    .ext_pin(reload_timer_ext_input),
    .tick(t_tick)
  );
  asp_reload_ctr u_tx_ctr (
    .clock(clock),
    .reset(reset),
    .run(run),
    .tick(t_tick),
    .force_load(1'b0),
    .load_en(wr_count),
    .load_val(wdata),
    .reload_val(reload_ff),
    .count(tx_count),
    .bit_tick(tx_bit)
  );
  asp_reload_ctr u_rx_ctr (
    .clock(clock),
    .reset(reset),
    .run(run),
    .tick(t_tick),
    .force_load(rx_start),
    .load_en(1'b0),
    .load_val(8'h00),
    .reload_val(reload_ff),
    .count(),
    .bit_tick(rx_bit)
  );
  // ==========================================
  // transmitter
  always_comb begin
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_pend = tx_pend_ff;
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_pin = tx_pin_ff;
    tx_done_set = 1'b0;
    if (wr_data) begin
      // start, data lsb first, ninth bit, stop
      nxt_tx_sh = mode9 ? {1'b1, ctrl_ff[`ASP_CTL_TB8], wdata}
                        : {2'b11, wdata};
      nxt_tx_pend = 1'b1;
      nxt_tx_busy = 1'b0;
      nxt_tx_pin = 1'b1;
    end else if (tx_bit) begin
      if (tx_pend_ff) begin
        nxt_tx_pend = 1'b0;
        nxt_tx_busy = 1'b1;
        nxt_tx_cnt = 4'h0;
        nxt_tx_pin = 1'b0;
      end else if (tx_busy_ff) begin
        nxt_tx_pin = tx_sh_ff[0];
        nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
        nxt_tx_cnt = tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == (mode9 ? `ASP_TX_BITS_9 : `ASP_TX_BITS_8) - 4'h1) begin
          tx_done_set = 1'b1;
        end
        if (tx_cnt_ff == (mode9 ? `ASP_TX_BITS_9 : `ASP_TX_BITS_8)) begin
          nxt_tx_busy = 1'b0;
          nxt_tx_pin = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_sh_ff <= 10'h3ff;
      tx_cnt_ff <= 4'h0;
      tx_pend_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      tx_pin_ff <= 1'b1;
    end else begin
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_pend_ff <= nxt_tx_pend;
      tx_busy_ff <= nxt_tx_busy;
      tx_pin_ff <= nxt_tx_pin;
    end
  end
  // ==========================================
  // receiver
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_prev = rx_pin;
    nxt_rx_buf = rx_buf_ff;
    rx_done_set = 1'b0;
    rx_last = mode9 ? `ASP_RX_LAST_9 : `ASP_RX_LAST_8;
    rx_ok = 1'b0;
    case (rx_st_ff)
      ASP_RX_IDLE: begin
        if (rx_start) begin
          nxt_rx_st = ASP_RX_START;
        end
      end
      ASP_RX_START: begin
        // first halved overflow lands mid start bit
        if (rx_bit) begin
          nxt_rx_st = rx_pin ? ASP_RX_IDLE : ASP_RX_DATA;
          nxt_rx_cnt = `ASP_RX_MID;
        end
      end
      ASP_RX_DATA: begin
        if (rx_bit) begin
          nxt_rx_cnt = rx_cnt_ff + 4'h1;
          if (rx_cnt_ff + 4'h1 == rx_last) begin
            // stop bit sampled from pin; shifter keeps ninth bit in msb, or data bit 7 in 8-bit mode
            rx_ok = !ctrl_ff[`ASP_CTL_RDONE] && (!ctrl_ff[`ASP_CTL_MCE]
                    || (mode9 ? rx_sh_ff[8] : rx_pin));
            if (rx_ok) begin
              nxt_rx_buf = mode9 ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
              rx_done_set = 1'b1;
            end
            nxt_rx_st = ASP_RX_IDLE;
          end else begin
            nxt_rx_sh = {rx_pin, rx_sh_ff[8:1]};
          end
        end
      end
      default: nxt_rx_st = ASP_RX_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_st_ff <= ASP_RX_IDLE;
      rx_sh_ff <= 9'h000;
      rx_cnt_ff <= 4'h0;
      rx_prev_ff <= 1'b1;
      rx_buf_ff <= 8'h00;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_prev_ff <= nxt_rx_prev;
      rx_buf_ff <= nxt_rx_buf;
    end
  end
  // ==========================================
  // registers, flags and interrupt
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_reload = reload_ff;
    nxt_tcfg = tcfg_ff;
    nxt_int_en = int_en_ff;
    nxt_int_stat = int_stat_ff;
    nxt_rdata = 8'h00;
    ev = {rx_done_set, tx_done_set};
    if (wr_ctrl) begin
      nxt_ctrl = wdata;
      nxt_ctrl[`ASP_CTL_UNUSED] = 1'b1;
    end
    if (hit(addr, `ASP_OFF_RELOAD, wr_en)) begin
      nxt_reload = wdata;
    end
    if (hit(addr, `ASP_OFF_TCFG, wr_en)) begin
      nxt_tcfg = wdata;
    end
    if (hit(addr, `ASP_OFF_INT_EN, wr_en)) begin
      nxt_int_en = wdata[1:0];
    end
    if (hit(addr, `ASP_OFF_INT_CLR, wr_en)) begin
      nxt_int_stat = int_stat_ff & ~wdata[1:0];
    end
    // hardware set wins over software clear
    nxt_int_stat = nxt_int_stat | ev;
    if (tx_done_set) begin
      nxt_ctrl[`ASP_CTL_TDONE] = 1'b1;
    end
    if (rx_done_set) begin
      nxt_ctrl[`ASP_CTL_RDONE] = 1'b1;
      nxt_ctrl[`ASP_CTL_RB8] = mode9 ? rx_sh_ff[8] : rx_pin;
    end
    nxt_irq = |(nxt_int_stat & nxt_int_en);
    if (rd_en) begin
      case (addr)
        `ASP_OFF_CTRL: nxt_rdata = ctrl_ff;
        `ASP_OFF_DATA: nxt_rdata = rx_buf_ff;
        `ASP_OFF_RELOAD: nxt_rdata = reload_ff;
        `ASP_OFF_TCFG: nxt_rdata = tcfg_ff;
        `ASP_OFF_COUNT: nxt_rdata = tx_count;
        `ASP_OFF_INT_STAT: nxt_rdata = {6'h00, int_stat_ff};
        `ASP_OFF_INT_EN: nxt_rdata = {6'h00, int_en_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_ff <= `ASP_CTL_RESET;
      reload_ff <= 8'h00;
      tcfg_ff <= `ASP_TCFG_RESET;
      int_stat_ff <= 2'h0;
      int_en_ff <= 2'h0;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      reload_ff <= nxt_reload;
      tcfg_ff <= nxt_tcfg;
      int_stat_ff <= nxt_int_stat;
      int_en_ff <= nxt_int_en;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end
  assign rdata = rdata_ff;
  assign tx_pin = tx_pin_ff;
  assign irq = irq_ff;
endmodule

// File: rtl/asp_map.svh
// register offsets, field positions, reset values and timing constants of the serial port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// ==========================================
// register offsets
`define ASP_OFF_CTRL 4'h0
`define ASP_OFF_DATA 4'h1
`define ASP_OFF_RELOAD 4'h2
`define ASP_OFF_TCFG 4'h3
`define ASP_OFF_COUNT 4'h4
`define ASP_OFF_INT_STAT 4'h5
`define ASP_OFF_INT_CLR 4'h6
`define ASP_OFF_INT_EN 4'h7
// ==========================================
// control register fields
`define ASP_CTL_MODE 7
`define ASP_CTL_UNUSED 6
`define ASP_CTL_MCE 5
`define ASP_CTL_REN 4
`define ASP_CTL_TB8 3
`define ASP_CTL_RB8 2
`define ASP_CTL_TDONE 1
`define ASP_CTL_RDONE 0
`define ASP_CTL_RESET 8'h40
// ==========================================
// timer config fields
`define ASP_TCFG_RUN 3
`define ASP_TCFG_SRC_HI 2
`define ASP_TCFG_SRC_LO 0
`define ASP_TCFG_RESET 8'h00
// ==========================================
// interrupt bits
`define ASP_INT_TX 0
`define ASP_INT_RX 1
// ==========================================
// prescale divisors and frame constants
`define ASP_DIV4 6'h03
`define ASP_DIV12 6'h0b
`define ASP_DIV48 6'h2f
`define ASP_DIV8 6'h07
`define ASP_TX_BITS_8 4'h9
`define ASP_TX_BITS_9 4'ha
`define ASP_RX_LAST_8 4'h9
`define ASP_RX_LAST_9 4'ha
`define ASP_RX_MID 4'h0
`endif

// File: rtl/asp_pkg.sv
// types shared by the serial port design files
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_SRC_CORE = 3'h0,
    ASP_SRC_DIV4 = 3'h1,
    ASP_SRC_DIV12 = 3'h2,
    ASP_SRC_DIV48 = 3'h3,
    ASP_SRC_EXT8 = 3'h4,
    ASP_SRC_PIN = 3'h5
  } asp_src_t;
  typedef enum logic [1:0] {
    ASP_RX_IDLE = 2'b00,
    ASP_RX_START = 2'b01,
    ASP_RX_DATA = 2'b11
  } asp_rx_state_t;
endpackage

// File: rtl/asp_tick_gen.sv
// timer clock prescaler: one-cycle tick from the selected source
`timescale 1ns/1ns
`include "asp_map.svh"
module asp_tick_gen import asp_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] src_sel,
  input wire logic ext_osc_tick,
  input wire logic ext_pin,
  output logic tick
);
  logic [5:0] pre_ff;
  logic [5:0] nxt_pre;
  logic [2:0] ext_ff;
  logic [2:0] nxt_ext;
  logic pin_ff;
  logic nxt_pin;
  logic div_hit;
  function automatic logic [5:0] asp_div(input logic [2:0] s);
    case (s)
      ASP_SRC_DIV4: asp_div = `ASP_DIV4;
      ASP_SRC_DIV12: asp_div = `ASP_DIV12;
      ASP_SRC_DIV48: asp_div = `ASP_DIV48;
      default: asp_div = 6'h00;
    endcase
  endfunction
  // ==========================================
  // prescale counters
  always_comb begin
    div_hit = (pre_ff >= asp_div(src_sel));
    nxt_pre = div_hit ? 6'h00 : pre_ff + 6'h01;
    nxt_ext = ext_osc_tick ? ext_ff + 3'h1 : ext_ff;
    nxt_pin = ext_pin;
    case (src_sel)
      ASP_SRC_CORE: tick = 1'b1;
      ASP_SRC_DIV4, ASP_SRC_DIV12, ASP_SRC_DIV48: tick = div_hit;
      ASP_SRC_EXT8: tick = ext_osc_tick && (ext_ff == 3'(`ASP_DIV8));
      ASP_SRC_PIN: tick = ext_pin && !pin_ff;
      default: tick = 1'b0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      pre_ff <= 6'h00;
      ext_ff <= 3'h0;
      pin_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      ext_ff <= nxt_ext;
      pin_ff <= nxt_pin;
    end
  end
endmodule

// File: rtl/asp_reload_ctr.sv
// 8-bit auto-reload counter with halving of overflows
`timescale 1ns/1ns
module asp_reload_ctr (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic tick,
  input wire logic force_load,
  input wire logic load_en,
  input wire logic [7:0] load_val,
  input wire logic [7:0] reload_val,
  output logic [7:0] count,
  output logic bit_tick
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic half_ff;
  logic nxt_half;
  logic ovf;
  // ==========================================
  // count, reload on overflow, divide by two
  always_comb begin
    ovf = run && tick && (cnt_ff == 8'hff);
    nxt_cnt = cnt_ff;
    nxt_half = half_ff;
    if (load_en) begin
      nxt_cnt = load_val;
    end else if (force_load) begin
      nxt_cnt = reload_val;
      nxt_half = 1'b1;
    end else if (ovf) begin
      nxt_cnt = reload_val;
      nxt_half = !half_ff;
    end else if (run && tick) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
    bit_tick = ovf && half_ff && !force_load && !load_en;
    count = cnt_ff;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_ff <= 8'h00;
      half_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      half_ff <= nxt_half;
    end
  end
endmodule

// File: dv/asp_top_properties.sv
// checker for the serial port top: assertions on its pins only
`timescale 1ns/1ns
`include "asp_map.svh"
module asp_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic ext_osc_tick,
  input wire logic reload_timer_ext_input,
  input wire logic irq
);
  logic [7:0] en_ff;
  logic [7:0] nxt_en;
  // ========
  // shadow of the interrupt enable register
  always_comb begin
    nxt_en = en_ff;
    if (wr_en && addr == `ASP_OFF_INT_EN) begin
      nxt_en = wdata;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      en_ff <= 8'h00;
    end else begin
      en_ff <= nxt_en;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ========
  // assertions
  reset_idle_a: assert property ($fell(reset) |-> tx_pin && !irq && rdata == 8'h00)
    else $error("outputs not idle after reset");
  rdata_quiet_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read answer");
  hole_zero_a: assert property ($past(rd_en) && ($past(addr) > 4'h7 ||
    $past(addr) == `ASP_OFF_INT_CLR) |-> rdata == 8'h00)
    else $error("unmapped or clear index read nonzero");
  ctrl_fixed_a: assert property ($past(rd_en) && $past(addr) == `ASP_OFF_CTRL |-> rdata[6])
    else $error("control bit 6 not one");
  start_bit_a: assert property ($fell(tx_pin) |=> !tx_pin)
    else $error("start bit shorter than two clocks");
  irq_masked_a: assert property (en_ff == 8'h00 && $past(en_ff) == 8'h00 |-> !irq)
    else $error("interrupt while all masked");
  irq_sticky_a: assert property (irq && !wr_en && !$past(wr_en) |=> irq)
    else $error("interrupt dropped without software write");
  en_off_a: assert property (wr_en && addr == `ASP_OFF_INT_EN && wdata == 8'h00 |-> ##2 !irq)
    else $error("interrupt still high after disable");
  clr_all_a: assert property (wr_en && addr == `ASP_OFF_INT_CLR && wdata == 8'h03 |-> ##2 !irq)
    else $error("interrupt still high after clear");
endmodule

// File: dv/asp_remote.sv
// remote serial transceiver model facing the port's pins
`timescale 1ns/1ns
module asp_remote (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  logic nine = 1'b0;
  logic [9:0] sh;
  logic [7:0] got_byte;
  logic got_ninth;
  logic got_stop;
  int start_len;
  int frames = 0;
  int bit_clks = 8;
  initial line_out = 1'b1;
  // ========
  // send one frame, line idles high after the stop bit
  task automatic send(input logic [7:0] b, input logic b9);
    logic [10:0] f;
    f = {1'b1, nine ? b9 : 1'b1, b, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clock);
      line_out <= f[i];
      repeat (bit_clks - 1) @(posedge clock);
    end
  endtask
  // ========
  // capture frames, measuring the start bit and sampling mid-bit
  always begin
    @(negedge line_in);
    start_len = 0;
    @(negedge clock);
    while (line_in === 1'b0) begin
      start_len++;
      @(negedge clock);
    end
    repeat (start_len / 2) @(negedge clock);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      sh[i] = line_in;
      if (i < (nine ? 9 : 8)) repeat (start_len) @(negedge clock);
    end
    got_byte = sh[7:0];
    got_ninth = sh[8];
    got_stop = nine ? sh[9] : sh[8];
    frames++;
  end
endmodule

// File: dv/tb.sv
// testbench: register tasks, remote transceiver and scenario sequence
`timescale 1ns/1ns
`include "asp_map.svh"
module tb import asp_pkg::*; ;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_osc_tick = 1'b0;
  logic ext_in = 1'b0;
  logic [7:0] rdata;
  logic rx_pin;
  logic tx_pin;
  logic irq;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int mult[6] = '{1, 4, 12, 48, 16, 4};
  asp_src_t src[6] = '{ASP_SRC_CORE, ASP_SRC_DIV4, ASP_SRC_DIV12, ASP_SRC_DIV48,
    ASP_SRC_EXT8, ASP_SRC_PIN};
`define ASP_CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h, expected %h", $time, got, exp); end end
  always #50 clock = ~clock;
  asp_top i_asp_top (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .ext_osc_tick(ext_osc_tick),
    .reload_timer_ext_input(ext_in), .irq(irq));
  asp_remote remote (.clock(clock), .line_in(tx_pin), .line_out(rx_pin));
  // ========
  // verdict, timer sources and timeout
  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ext_osc_tick <= ~ext_osc_tick;
    ext_in <= cyc[1];
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  // ========
  // register access tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    `ASP_CHECK(rdata, exp)
    @(posedge clock);
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge clock);
  endtask
  task automatic clr(input logic [7:0] ctl);
    wr(`ASP_OFF_INT_CLR, 8'h03);
    wr(`ASP_OFF_CTRL, ctl);
  endtask
  task automatic tx(input logic [7:0] b, input int n);
    wr(`ASP_OFF_DATA, b);
    wait_irq();
    `ASP_CHECK(tx_pin, 1'b1)
    `ASP_CHECK(remote.frames, n - 1)
    for (int k = 0; k < 9000 && remote.frames < n; k++) @(posedge clock);
    `ASP_CHECK(remote.got_byte, b)
    `ASP_CHECK(remote.got_stop, 1'b1)
  endtask
  // ========
  // scenarios
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk(`ASP_OFF_CTRL, 8'h40);
    chk(`ASP_OFF_INT_CLR, 8'h00);
    chk(4'hf, 8'h00);
    wr(`ASP_OFF_RELOAD, 8'hfc);
    wr(`ASP_OFF_INT_EN, 8'h03);
    wr(`ASP_OFF_CTRL, 8'h10);
    for (int i = 0; i < 6; i++) begin
      wr(`ASP_OFF_TCFG, {5'h01, src[i]});
      tx(8'h41 + 8'(2 * i), i + 1);
      `ASP_CHECK(remote.start_len, 2 * (256 - 'hfc) * mult[i])
      chk(`ASP_OFF_INT_STAT, 8'h01);
      chk(`ASP_OFF_CTRL, 8'h52);
      clr(8'h10);
    end
    wr(`ASP_OFF_TCFG, 8'h08);
    remote.nine = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`ASP_OFF_CTRL, 8'h90 | 8'(8 * i));
      tx(8'h3d, 7 + i);
      `ASP_CHECK(remote.got_ninth, 1'(i))
      clr(8'h90);
    end
    remote.nine = 1'b0;
    wr(`ASP_OFF_CTRL, 8'h10);
    fork
      begin
        remote.send(8'h5a, 1'b1);
        remote.send(8'hc3, 1'b1);
      end
      begin
        wait_irq();
        chk(`ASP_OFF_DATA, 8'h5a);
        chk(`ASP_OFF_CTRL, 8'h55);
        clr(8'h10);
      end
    join
    wait_irq();
    chk(`ASP_OFF_DATA, 8'hc3);
    remote.send(8'h11, 1'b1);
    repeat (20) @(posedge clock);
    chk(`ASP_OFF_DATA, 8'hc3);
    clr(8'h10);
    remote.nine = 1'b1;
    wr(`ASP_OFF_CTRL, 8'hb0);
    remote.send(8'h22, 1'b0);
    repeat (20) @(posedge clock);
    chk(`ASP_OFF_INT_STAT, 8'h00);
    remote.send(8'h33, 1'b1);
    wait_irq();
    chk(`ASP_OFF_DATA, 8'h33);
    chk(`ASP_OFF_CTRL, 8'hf5);
    clr(8'h90);
    tx(8'h99, 9);
    chk(`ASP_OFF_DATA, 8'h33);
    wr(`ASP_OFF_INT_EN, 8'h00);
    @(posedge clock);
    `ASP_CHECK(irq, 1'b0)
    chk(`ASP_OFF_INT_STAT, 8'h01);
    wr(`ASP_OFF_INT_EN, 8'h03);
    @(posedge clock);
    `ASP_CHECK(irq, 1'b1)
    clr(8'h90);
    @(posedge clock);
    `ASP_CHECK(irq, 1'b0)
    stop_test();
  end
endmodule
bind asp_top asp_checker chk_props (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .ext_osc_tick(ext_osc_tick), .reload_timer_ext_input(reload_timer_ext_input), .irq(irq));
